// ---- src/ifc_bus_if.sv ----
`timescale 1ns/100ps
interface ifc_bus_if;
    logic scl;
    logic sda_m_out;
    logic sda_m_oe_n;
    logic sda_s_out;
    logic sda_s_oe_n;
    logic serial_data_line;

    // Open drain with pull-up: low when any enabled driver pulls low
    assign serial_data_line = ~((~sda_m_oe_n & ~sda_m_out) |
                                (~sda_s_oe_n & ~sda_s_out));

    modport master (output scl, output sda_m_out, output sda_m_oe_n,
                    input serial_data_line);
    modport slave (input scl, input serial_data_line,
                   output sda_s_out, output sda_s_oe_n);
endinterface : ifc_bus_if

// ---- src/ifc_device.sv ----
`timescale 1ns/100ps
module ifc_device #(
    parameter int PAIRS = ifc_pkg::NUM_PAIRS
) (
    input wire logic LINK_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic REF_CLK_IN,
    input wire logic POWER_DOWN_N_IN,
    ifc_bus_if.slave BUS,
    output logic [PAIRS-1:0] PAIR_TRUE_OUT,
    output logic [PAIRS-1:0] PAIR_COMP_OUT,
    output logic FEEDBACK_CLK_OUT,
    output logic CLK_OE_N_OUT,
    output logic DRIVE_BOOST_OUT
);
    ifc_pkg::ifc_dev_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] idx_r, idx_nxt;
    logic rw_r, rw_nxt;
    logic mack_r, mack_nxt;
    logic drv_r, drv_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic [7:0] lo_r, lo_nxt;
    logic boost_r, boost_nxt;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f_r, sda_f_r;
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] tx_byte;
    logic [PAIRS-1:0] pair_en;

    // Control byte image seen by a block read
    function automatic logic [7:0] ctrl_byte(input logic [3:0] n,
        input logic [7:0] hi, input logic [7:0] lo);
        if (n == ifc_pkg::CTRL_HI_IDX)
            ctrl_byte = hi;
        else if (n == ifc_pkg::CTRL_LO_IDX)
            ctrl_byte = lo;
        else
            ctrl_byte = 8'h00;
    endfunction : ctrl_byte

    // Filtered bus levels: a change counts once two samples agree
    assign scl_q = (scl_s[1] == scl_s[2]) ? scl_s[1] : scl_f_r;
    assign sda_q = (sda_s[1] == sda_s[2]) ? sda_s[1] : sda_f_r;
    assign scl_rise = scl_q & ~scl_f_r;
    assign scl_fall = ~scl_q & scl_f_r;
    assign start_cond = scl_q & scl_f_r & sda_f_r & ~sda_q;
    assign stop_cond = scl_q & scl_f_r & ~sda_f_r & sda_q;
    assign tx_byte = ctrl_byte(idx_r, hi_r, lo_r);

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        idx_nxt = idx_r;
        rw_nxt = rw_r;
        mack_nxt = mack_r;
        drv_nxt = drv_r;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        boost_nxt = hi_r[ifc_pkg::DRIVE_BIT];
        if (start_cond)
        begin
            st_nxt = ifc_pkg::DEV_ADDR;
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
        end
        else if (stop_cond)
        begin
            st_nxt = ifc_pkg::DEV_IDLE;
            drv_nxt = 1'b0;
        end
        else
        begin
            case (st_r)
                ifc_pkg::DEV_IDLE:
                    drv_nxt = 1'b0;
                ifc_pkg::DEV_ADDR, ifc_pkg::DEV_RX:
                begin
                    if (scl_rise && cnt_r < ifc_pkg::BITS_PER_BYTE)
                    begin
                        sh_nxt = {sh_r[6:0], sda_q};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    if (scl_fall && cnt_r == ifc_pkg::BITS_PER_BYTE)
                    begin
                        if (st_r == ifc_pkg::DEV_ADDR)
                        begin
                            if (sh_r[7:1] == ifc_pkg::WR_ADDR_BYTE[7:1])
                            begin
                                rw_nxt = sh_r[0];
                                idx_nxt = 4'h0;
                                drv_nxt = 1'b1;
                                st_nxt = ifc_pkg::DEV_ACK;
                            end
                            else
                                st_nxt = ifc_pkg::DEV_IDLE;
                        end
                        else
                        begin
                            // Command and count land below the data slots
                            if (idx_r == ifc_pkg::HDR_BYTES +
                                ifc_pkg::CTRL_HI_IDX)
                                hi_nxt = (sh_r & ifc_pkg::CTRL_HI_WMASK) |
                                    (ifc_pkg::CTRL_HI_RST &
                                     ~ifc_pkg::CTRL_HI_WMASK);
                            if (idx_r == ifc_pkg::HDR_BYTES +
                                ifc_pkg::CTRL_LO_IDX)
                                lo_nxt = sh_r;
                            if (idx_r != ifc_pkg::IDX_MAX)
                                idx_nxt = idx_r + 4'h1;
                            drv_nxt = 1'b1;
                            st_nxt = ifc_pkg::DEV_ACK;
                        end
                    end
                end
                ifc_pkg::DEV_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        if (rw_r)
                        begin
                            sh_nxt = tx_byte;
                            drv_nxt = ~tx_byte[7];
                            st_nxt = ifc_pkg::DEV_TX;
                        end
                        else
                        begin
                            drv_nxt = 1'b0;
                            st_nxt = ifc_pkg::DEV_RX;
                        end
                    end
                end
                ifc_pkg::DEV_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_r == ifc_pkg::LAST_BIT)
                        begin
                            drv_nxt = 1'b0;
                            mack_nxt = 1'b0;
                            if (idx_r != ifc_pkg::IDX_MAX)
                                idx_nxt = idx_r + 4'h1;
                            st_nxt = ifc_pkg::DEV_MACK;
                        end
                        else
                        begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            drv_nxt = ~sh_r[6];
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                ifc_pkg::DEV_MACK:
                begin
                    if (scl_rise)
                        mack_nxt = ~sda_q;
                    if (scl_fall)
                    begin
                        cnt_nxt = 4'h0;
                        if (mack_r)
                        begin
                            sh_nxt = tx_byte;
                            drv_nxt = ~tx_byte[7];
                            st_nxt = ifc_pkg::DEV_TX;
                        end
                        else
                            st_nxt = ifc_pkg::DEV_IDLE;
                    end
                end
                default: st_nxt = ifc_pkg::DEV_IDLE;
            endcase
        end
    end

    always_ff @(posedge LINK_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            st_r <= ifc_pkg::DEV_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            idx_r <= 4'h0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            drv_r <= 1'b0;
            hi_r <= ifc_pkg::CTRL_HI_RST;
            lo_r <= ifc_pkg::CTRL_LO_RST;
            boost_r <= 1'b0;
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            idx_r <= idx_nxt;
            rw_r <= rw_nxt;
            mack_r <= mack_nxt;
            drv_r <= drv_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            boost_r <= boost_nxt;
            scl_s <= {scl_s[1:0], BUS.scl};
            sda_s <= {sda_s[1:0], BUS.serial_data_line};
            scl_f_r <= scl_q;
            sda_f_r <= sda_q;
        end
    end

    // Enables change only after a serial write, so gating the reference
    // asynchronously may shorten one output pulse; accepted for a buffer
    assign pair_en = {hi_r[ifc_pkg::HI_PAIRS-1:0], lo_r};

    genvar gi;
    generate
        for (gi = 0; gi < PAIRS; gi = gi + 1)
        begin : g_pair
            // Disabled pair parks true low, complement high
            assign PAIR_TRUE_OUT[gi] =
                REF_CLK_IN & pair_en[gi];
            assign PAIR_COMP_OUT[gi] =
                ~(REF_CLK_IN & pair_en[gi]);
        end
    endgenerate

    assign FEEDBACK_CLK_OUT = REF_CLK_IN;
    assign CLK_OE_N_OUT = ~POWER_DOWN_N_IN;
    assign DRIVE_BOOST_OUT = boost_r;
    assign BUS.sda_s_out = 1'b0;
    assign BUS.sda_s_oe_n = ~drv_r;
endmodule : ifc_device

// ---- src/ifc_host.sv ----
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module ifc_host #(
    parameter int QTR = ifc_pkg::QTR_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic APB_PSEL_IN,
    input wire logic APB_PENABLE_IN,
    input wire logic APB_PWRITE_IN,
    input wire logic [7:0] APB_PADDR_IN,
    input wire logic [31:0] APB_PWDATA_IN,
    output logic [31:0] APB_PRDATA_OUT,
    output logic APB_PREADY_OUT,
    output logic APB_PSLVERR_OUT,
    ifc_bus_if.master BUS
);
    ifc_pkg::ifc_host_state_t st_r, st_nxt;
    logic [11:0] tick_r, tick_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [3:0] byte_r, byte_nxt;
    logic rw_r, rw_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic scl_r, scl_nxt;
    logic drv_r, drv_nxt;
    logic nack_r, nack_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [2:0] sda_s;
    logic sda_f_r, sda_q;
    logic wr_acc, tick, rx_byte, go_wr, go_rd;

    function automatic logic [7:0] host_byte(input logic rw,
        input logic [3:0] idx, input logic [15:0] wd);
        logic [3:0] first;
        first = ifc_pkg::HDR_BYTES + 4'h1;
        if (rw)
            host_byte = ifc_pkg::RD_ADDR_BYTE;
        else if (idx == 4'h0)
            host_byte = ifc_pkg::WR_ADDR_BYTE;
        else if (idx == 4'h1)
            host_byte = ifc_pkg::CMD_CODE;
        else if (idx == ifc_pkg::HDR_BYTES)
            host_byte = ifc_pkg::BLOCK_COUNT;
        else if (idx == first + ifc_pkg::CTRL_HI_IDX)
            host_byte = wd[7:0];
        else if (idx == first + ifc_pkg::CTRL_LO_IDX)
            host_byte = wd[15:8];
        else
            host_byte = 8'h00;
    endfunction : host_byte

    assign wr_acc = APB_PSEL_IN & APB_PENABLE_IN & APB_PWRITE_IN;
    assign go_wr = wr_acc & (APB_PADDR_IN == ifc_pkg::REG_CMD_OFS) &
                   APB_PWDATA_IN[ifc_pkg::CMD_WR_BIT];
    assign go_rd = wr_acc & (APB_PADDR_IN == ifc_pkg::REG_CMD_OFS) &
                   APB_PWDATA_IN[ifc_pkg::CMD_RD_BIT];
    assign tick = (tick_r == 12'(QTR - 1));
    assign rx_byte = rw_r & (byte_r != 4'h0);
    assign sda_q = (sda_s[1] == sda_s[2]) ? sda_s[1] : sda_f_r;

    always_comb
    begin
        st_nxt = st_r;
        tick_nxt = tick_r;
        ph_nxt = ph_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        rw_nxt = rw_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        scl_nxt = scl_r;
        drv_nxt = drv_r;
        nack_nxt = nack_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        prdata_nxt = prdata_r;
        if (wr_acc && APB_PADDR_IN == ifc_pkg::REG_WDATA_OFS)
            wdata_nxt = APB_PWDATA_IN[15:0];
        if (APB_PSEL_IN && !APB_PENABLE_IN)
        begin
            case (APB_PADDR_IN)
                ifc_pkg::REG_WDATA_OFS: prdata_nxt = {16'h0000, wdata_r};
                ifc_pkg::REG_RDATA_OFS: prdata_nxt = {16'h0000, rdata_r};
                ifc_pkg::REG_STAT_OFS: prdata_nxt = {30'h00000000, nack_r,
                    st_r != ifc_pkg::HST_IDLE};
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        if (st_r != ifc_pkg::HST_IDLE)
        begin
            tick_nxt = tick ? 12'h000 : tick_r + 12'h001;
            if (tick)
                ph_nxt = ph_r + 2'h1;
        end
        case (st_r)
            ifc_pkg::HST_IDLE:
            begin
                scl_nxt = 1'b1;
                drv_nxt = 1'b0;
                if (go_wr || go_rd)
                begin
                    rw_nxt = go_rd & ~go_wr;
                    byte_nxt = 4'h0;
                    nack_nxt = 1'b0;
                    tick_nxt = 12'h000;
                    ph_nxt = 2'h0;
                    st_nxt = ifc_pkg::HST_START;
                end
            end
            ifc_pkg::HST_START:
            begin
                if (tick && ph_r == 2'h1)
                    drv_nxt = 1'b1;
                if (tick && ph_r == 2'h3)
                begin
                    scl_nxt = 1'b0;
                    bit_nxt = 4'h0;
                    tx_nxt = host_byte(rw_r, 4'h0, wdata_r);
                    st_nxt = ifc_pkg::HST_BIT;
                end
            end
            ifc_pkg::HST_BIT:
            begin
                if (tick && ph_r == 2'h0)
                begin
                    if (bit_r < ifc_pkg::BITS_PER_BYTE)
                        drv_nxt = ~rx_byte & ~tx_r[7];
                    else
                        drv_nxt = rx_byte & (byte_r != ifc_pkg::RD_LAST);
                end
                if (tick && ph_r == 2'h1)
                    scl_nxt = 1'b1;
                if (tick && ph_r == 2'h2)
                begin
                    if (bit_r < ifc_pkg::BITS_PER_BYTE)
                    begin
                        rx_nxt = {rx_r[6:0], sda_q};
                        tx_nxt = {tx_r[6:0], 1'b0};
                    end
                    else if (!rx_byte && sda_q)
                        nack_nxt = 1'b1;
                end
                if (tick && ph_r == 2'h3)
                begin
                    scl_nxt = 1'b0;
                    if (bit_r < ifc_pkg::BITS_PER_BYTE)
                        bit_nxt = bit_r + 4'h1;
                    else
                    begin
                        if (rx_byte && byte_r == ifc_pkg::CTRL_LO_IDX)
                            rdata_nxt[7:0] = rx_r;
                        if (rx_byte && byte_r == ifc_pkg::RD_LAST)
                            rdata_nxt[15:8] = rx_r;
                        if (nack_r || byte_r == (rw_r ? ifc_pkg::RD_LAST :
                                                 ifc_pkg::WR_LAST))
                            st_nxt = ifc_pkg::HST_STOP;
                        else
                        begin
                            byte_nxt = byte_r + 4'h1;
                            bit_nxt = 4'h0;
                            tx_nxt = host_byte(1'b0, byte_r + 4'h1, wdata_r);
                        end
                    end
                end
            end
            ifc_pkg::HST_STOP:
            begin
                if (tick && ph_r == 2'h0)
                    drv_nxt = 1'b1;
                if (tick && ph_r == 2'h1)
                    scl_nxt = 1'b1;
                if (tick && ph_r == 2'h2)
                    drv_nxt = 1'b0;
                if (tick && ph_r == 2'h3)
                    st_nxt = ifc_pkg::HST_IDLE;
            end
            default: st_nxt = ifc_pkg::HST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            st_r <= ifc_pkg::HST_IDLE;
            tick_r <= 12'h000;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= 4'h0;
            rw_r <= 1'b0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            scl_r <= 1'b1;
            drv_r <= 1'b0;
            nack_r <= 1'b0;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            prdata_r <= 32'h00000000;
            sda_s <= 3'h7;
            sda_f_r <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
            tick_r <= tick_nxt;
            ph_r <= ph_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            rw_r <= rw_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            scl_r <= scl_nxt;
            drv_r <= drv_nxt;
            nack_r <= nack_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            prdata_r <= prdata_nxt;
            sda_s <= {sda_s[1:0], BUS.serial_data_line};
            sda_f_r <= sda_q;
        end
    end

    assign BUS.scl = scl_r;
    assign BUS.sda_m_out = 1'b0;
    assign BUS.sda_m_oe_n = ~drv_r;
    assign APB_PRDATA_OUT = prdata_r;
    assign APB_PREADY_OUT = 1'b1;
    assign APB_PSLVERR_OUT = APB_PSEL_IN & APB_PENABLE_IN &
        (APB_PADDR_IN[1:0] != 2'h0 || APB_PADDR_IN > ifc_pkg::REG_STAT_OFS);
endmodule : ifc_host

// ---- src/ifc_pkg.sv ----
package ifc_pkg;
    // Serial addressing and block framing
    localparam logic [7:0] WR_ADDR_BYTE = 8'hD2;
    localparam logic [7:0] RD_ADDR_BYTE = 8'hD3;
    localparam logic [7:0] CMD_CODE = 8'h00;
    localparam logic [7:0] BLOCK_COUNT = 8'h08;
    localparam logic [3:0] HDR_BYTES = 4'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] WR_LAST = 4'hA;
    localparam logic [3:0] RD_LAST = 4'h8;
    localparam logic [3:0] IDX_MAX = 4'hF;
    // Control bytes of the device
    localparam logic [3:0] CTRL_HI_IDX = 4'h6;
    localparam logic [3:0] CTRL_LO_IDX = 4'h7;
    localparam logic [7:0] CTRL_HI_RST = 8'h8F;
    localparam logic [7:0] CTRL_LO_RST = 8'hFF;
    localparam logic [7:0] CTRL_HI_WMASK = 8'h2F;
    localparam int DRIVE_BIT = 5;
    localparam int HI_PAIRS = 4;
    localparam int NUM_PAIRS = 12;
    // Controller registers, byte addresses on APB
    localparam logic [7:0] REG_CMD_OFS = 8'h00;
    localparam logic [7:0] REG_WDATA_OFS = 8'h04;
    localparam logic [7:0] REG_RDATA_OFS = 8'h08;
    localparam logic [7:0] REG_STAT_OFS = 8'h0C;
    localparam int CMD_WR_BIT = 0;
    localparam int CMD_RD_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
    // Serial clock timing
    localparam int CORE_CLK_HZ = 100000000;
    localparam int SCL_MAX_HZ = 100000;
    localparam int BIT_CYC = (CORE_CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;
    localparam int QTR_CYC = (BIT_CYC + 3) / 4;

    typedef enum {DEV_IDLE, DEV_ADDR, DEV_RX, DEV_ACK, DEV_TX, DEV_MACK}
        ifc_dev_state_t;
    typedef enum {HST_IDLE, HST_START, HST_BIT, HST_STOP} ifc_host_state_t;
endpackage : ifc_pkg

// ---- verif/ifc_link_props.sv ----
`timescale 1ns/100ps
module ifc_link_props #(
    parameter int QTR = ifc_pkg::QTR_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic LINK_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic scl,
    input wire logic sda_s_oe_n,
    input wire logic REF_CLK_IN,
    input wire logic POWER_DOWN_N_IN,
    input wire logic [11:0] PAIR_TRUE_OUT,
    input wire logic [11:0] PAIR_COMP_OUT,
    input wire logic FEEDBACK_CLK_OUT,
    input wire logic CLK_OE_N_OUT,
    input wire logic DRIVE_BOOST_OUT
);
    logic scl_d_r;
    logic [15:0] hold_r;
    logic [15:0] hold_nxt;
    // Saturates so a long idle bus cannot wrap
    always_comb
    begin
        hold_nxt = hold_r;
        if (scl != scl_d_r)
            hold_nxt = 16'h0000;
        else if (hold_r != 16'hFFFF)
            hold_nxt = hold_r + 16'h0001;
    end
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            scl_d_r <= 1'h1;
            hold_r <= 16'h0000;
        end
        else
        begin
            scl_d_r <= scl;
            hold_r <= hold_nxt;
        end
    end
    a_scl_phase_len:
        assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
            $changed(scl) |-> hold_r >= 2 * QTR - 2)
        else $error("serial clock phase too short");
    a_sda_scl_low:
        assert property (@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
            $changed(sda_s_oe_n) |-> !scl)
        else $error("device moved data while clock high");
    a_comp_inverts:
        assert property (@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
            PAIR_COMP_OUT == ~PAIR_TRUE_OUT)
        else $error("complement not inverse of true");
    a_true_ref_low:
        assert property (@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
            !REF_CLK_IN |-> PAIR_TRUE_OUT == 12'h000)
        else $error("true output high with reference low");
    a_feedback_copy:
        assert property (@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
            FEEDBACK_CLK_OUT == REF_CLK_IN)
        else $error("feedback differs from reference");
    a_oe_power_down:
        assert property (@(posedge CORE_CLK_IN) disable iff (!RST_B_IN)
            CLK_OE_N_OUT == !POWER_DOWN_N_IN)
        else $error("output enable not following power down");
    a_boost_at_reset:
        assert property (@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
            $rose(RST_B_IN) |-> !DRIVE_BOOST_OUT)
        else $error("boost set after reset");
    a_pairs_at_reset:
        assert property (@(posedge LINK_CLK_IN) disable iff (!RST_B_IN)
            $rose(RST_B_IN) |-> PAIR_TRUE_OUT == {12{REF_CLK_IN}})
        else $error("pair disabled after reset");
endmodule : ifc_link_props

// ---- verif/tb_i2c_clock_fanout_enable_ctrl.sv ----
`timescale 1ns/100ps
module tb_i2c_clock_fanout_enable_ctrl;
    logic core_clk = 1'h0;
    logic link_clk = 1'h0;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic pd_n = 1'h1;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] ptrue;
    logic [11:0] pcomp;
    logic fb;
    logic oe_n;
    logic boost;
    logic [31:0] q;
    logic e;
    int fail_count = 0;
    int checks_done = 0;
    ifc_bus_if bus ();
    always #5 core_clk = ~core_clk;
    // Odd offset keeps the link clock out of phase with the core
    initial #0.7 forever #3 link_clk = ~link_clk;
    always #7 ref_clk = ~ref_clk;
    ifc_host #(.QTR(5)) u_ifc_host (.CORE_CLK_IN(core_clk),
        .RST_B_IN(rst_b), .APB_PSEL_IN(psel), .APB_PENABLE_IN(pen),
        .APB_PWRITE_IN(pwr), .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata),
        .APB_PRDATA_OUT(prdata), .APB_PREADY_OUT(pready),
        .APB_PSLVERR_OUT(pslverr), .BUS(bus));
    ifc_device u_ifc_device (.LINK_CLK_IN(link_clk), .RST_B_IN(rst_b),
        .REF_CLK_IN(ref_clk), .POWER_DOWN_N_IN(pd_n), .BUS(bus),
        .PAIR_TRUE_OUT(ptrue), .PAIR_COMP_OUT(pcomp),
        .FEEDBACK_CLK_OUT(fb), .CLK_OE_N_OUT(oe_n),
        .DRIVE_BOOST_OUT(boost));
    ifc_link_props #(.QTR(5)) u_props (.CORE_CLK_IN(core_clk),
        .LINK_CLK_IN(link_clk), .RST_B_IN(rst_b), .scl(bus.scl),
        .sda_s_oe_n(bus.sda_s_oe_n), .REF_CLK_IN(ref_clk),
        .POWER_DOWN_N_IN(pd_n), .PAIR_TRUE_OUT(ptrue),
        .PAIR_COMP_OUT(pcomp), .FEEDBACK_CLK_OUT(fb),
        .CLK_OE_N_OUT(oe_n), .DRIVE_BOOST_OUT(boost));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        pen <= 1'h1;
        @(posedge core_clk);
        while (pready !== 1'h1)
            @(posedge core_clk);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb
    // Start a block transfer and poll status until idle
    task automatic run(input logic [1:0] cmd);
        int n;
        n = 0;
        apb(1'h1, ifc_pkg::REG_CMD_OFS, {30'h0, cmd});
        do
        begin
            apb(1'h0, ifc_pkg::REG_STAT_OFS, 32'h0);
            n++;
        end
        while (q[0] !== 1'h0 && n < 4000);
        chk(q, 32'h0);
    endtask : run
    task automatic outs(input logic [11:0] en);
        @(posedge ref_clk);
        #1;
        chk({20'h0, ptrue}, {20'h0, en});
        chk({20'h0, pcomp}, {20'h0, ~en});
        chk({31'h0, fb}, 32'h1);
        @(negedge ref_clk);
        #1;
        chk({20'h0, pcomp}, 32'hFFF);
    endtask : outs
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'h1;
        repeat (4) @(posedge core_clk);
        outs(12'hFFF);
        chk({31'h0, boost}, 32'h0);
        run(2'h2);
        apb(1'h0, ifc_pkg::REG_RDATA_OFS, 32'h0);
        chk(q, 32'h0000FF8F);
        apb(1'h1, ifc_pkg::REG_WDATA_OFS, 32'h00005AF5);
        run(2'h1);
        repeat (8) @(posedge core_clk);
        chk({31'h0, boost}, 32'h1);
        outs(12'h55A);
        run(2'h2);
        apb(1'h0, ifc_pkg::REG_RDATA_OFS, 32'h0);
        chk(q, 32'h00005AA5);
        pd_n <= 1'h0;
        @(posedge core_clk);
        chk({31'h0, oe_n}, 32'h1);
        pd_n <= 1'h1;
        apb(1'h0, 8'h10, 32'h0);
        chk({31'h0, oe_n}, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'h1, ifc_pkg::REG_WDATA_OFS, 32'h0000FFDF);
        run(2'h1);
        repeat (8) @(posedge core_clk);
        chk({31'h0, boost}, 32'h0);
        outs(12'hFFF);
        summarize();
    end
    // Four transfers need roughly 7400 cycles
    initial
    begin
        #400000;
        fail_count++;
        summarize();
    end
endmodule : tb_i2c_clock_fanout_enable_ctrl
